// ### logic/btp_boundary_test.v
// Contract
// RULE1: two select bits pick one of four operations
// RULE2: operation runs only under run instruction in idle
// RULE3: control cells 17 and 16 never stepped
// RULE4: output-enable cell still gates output drive
// RULE5: toggle mode samples inputs, updates input shadows
// RULE6: toggle mode inverts output cells, updates on fall
// RULE7: pattern mode steps 16-bit lfsr, updates on fall
// RULE8: all-zero seed keeps generator at zero
// RULE9: controller scans a seed before running
// RULE10: signature mode folds inputs into 16-bit signature
// RULE11: signature mode holds output shadow latches
// RULE12: combined mode compresses inputs into 8-bit signature
// RULE13: combined mode steps 8-bit pattern on outputs
// RULE14: serial, mode and data inputs taken on rise
// RULE15: serial and data outputs change on fall
// RULE16: controller changes mode select on falling edge
// RULE17: shift states move one bit per clock
// RULE18: instruction capture loads 10000001
// RULE19: controller drives mode low to leave reset
// RULE20: controller loads select field before run instruction
// RULE21: serial output enabled in shift, off in exit1
// RULE22: update-ir moves instruction in on fall
// RULE23: fixed maximal-length polynomials per width
// RULE24: only two select bits decide operation
`include "btp_defines.vh"
`default_nettype none
module btp_boundary_test (
  input wire CLK,
  input wire RESETN,
  input wire TCK,
  input wire TMS,
  input wire TDI,
  input wire [7:0] D,
  input wire [7:0] CORE_Q,
  output reg TDO_OUT,
  output reg TDO_OE,
  output reg [7:0] Q_OUT,
  output reg Q_OE,
  output reg [7:0] CORE_D,
  output reg TEST_MODE
);
  // tap state step
  function [`BTP_ST_W-1:0] tap_next;
    input [`BTP_ST_W-1:0] st;
    input tms;
    begin
      case (st)
        `BTP_ST_TLR: tap_next = tms ? `BTP_ST_TLR : `BTP_ST_RTI;
        `BTP_ST_RTI: tap_next = tms ? `BTP_ST_SDS : `BTP_ST_RTI;
        `BTP_ST_SDS: tap_next = tms ? `BTP_ST_SIS : `BTP_ST_CDR;
        `BTP_ST_CDR: tap_next = tms ? `BTP_ST_E1D : `BTP_ST_SDR;
        `BTP_ST_SDR: tap_next = tms ? `BTP_ST_E1D : `BTP_ST_SDR;
        `BTP_ST_E1D: tap_next = tms ? `BTP_ST_UDR : `BTP_ST_PDR;
        `BTP_ST_PDR: tap_next = tms ? `BTP_ST_E2D : `BTP_ST_PDR;
        `BTP_ST_E2D: tap_next = tms ? `BTP_ST_UDR : `BTP_ST_SDR;
        `BTP_ST_UDR: tap_next = tms ? `BTP_ST_SDS : `BTP_ST_RTI;
        `BTP_ST_SIS: tap_next = tms ? `BTP_ST_TLR : `BTP_ST_CIR;
        `BTP_ST_CIR: tap_next = tms ? `BTP_ST_E1I : `BTP_ST_SIR;
        `BTP_ST_SIR: tap_next = tms ? `BTP_ST_E1I : `BTP_ST_SIR;
        `BTP_ST_E1I: tap_next = tms ? `BTP_ST_UIR : `BTP_ST_PIR;
        `BTP_ST_PIR: tap_next = tms ? `BTP_ST_E2I : `BTP_ST_PIR;
        `BTP_ST_E2I: tap_next = tms ? `BTP_ST_UIR : `BTP_ST_SIR;
        `BTP_ST_UIR: tap_next = tms ? `BTP_ST_SDS : `BTP_ST_RTI;
        default: tap_next = `BTP_ST_TLR;
      endcase
    end
  endfunction

  // instruction decode, bit 7 ignored
  function [`BTP_CL_W-1:0] ir_class;
    input [`BTP_IR_W-1:0] ir;
    begin
      case (ir & `BTP_IR_CODE_MASK)
        `BTP_OP_SAMPLE: ir_class = `BTP_CL_SAMPLE;
        `BTP_OP_EXTEST: ir_class = `BTP_CL_BSCAN;
        `BTP_OP_RUN_OPERATION_INSTRUCTION: ir_class = `BTP_CL_RUN;
        `BTP_OP_SCANCN: ir_class = `BTP_CL_CTLSCAN;
        `BTP_OP_SCANCT: ir_class = `BTP_CL_CTLSCAN;
        default: ir_class = `BTP_CL_BYPASS;
      endcase
    end
  endfunction

  function is_test;
    input [`BTP_IR_W-1:0] ir;
    begin
      is_test = ((ir & `BTP_IR_CODE_MASK) == `BTP_OP_EXTEST) ||
                ((ir & `BTP_IR_CODE_MASK) == `BTP_OP_RUN_OPERATION_INSTRUCTION) ||
                ((ir & `BTP_IR_CODE_MASK) == `BTP_OP_SCANCT);
    end
  endfunction

  wire [`BTP_SYNC_W-1:0] sync_w;
  wire tck_s;
  wire tms_s;
  wire tdi_s;
  wire [7:0] d_s;
  reg tck_p_q;
  reg [`BTP_ST_W-1:0] st_q;
  reg [`BTP_IR_W-1:0] ir_sh_q;
  reg [`BTP_IR_W-1:0] ir_q;
  reg byp_q;
  reg [`BTP_BSR_W-1:0] sh_q;
  reg [`BTP_BSR_W-1:0] upd_q;
  reg [`BTP_OPSEL_W-1:0] sel_sh_q;
  reg [`BTP_OPSEL_W-1:0] sel_q;
  wire tck_rise;
  wire tck_fall;
  wire [`BTP_CL_W-1:0] cls;
  wire run_active;
  wire [15:0] prpg16;
  wire [15:0] psa16;
  wire [7:0] psa8;
  wire [7:0] prpg8;
  reg serial_bit;

  btp_sync #(.W(`BTP_SYNC_W)) u_sync (
    .clk(CLK),
    .resetn(RESETN),
    .async_in({TCK, TMS, TDI, D}),
    .sync_out(sync_w)
  );
  // tck, tms, tdi and d share the same latency, so data lines up with tck; CORE_Q is not synchronised [RULE14]
  assign tck_s = sync_w[`BTP_SYNC_TCK];
  assign tms_s = sync_w[`BTP_SYNC_TMS];
  assign tdi_s = sync_w[`BTP_SYNC_TDI];
  assign d_s = sync_w[`BTP_DATA_W-1:0];
  assign tck_rise = tck_s & ~tck_p_q;
  assign tck_fall = ~tck_s & tck_p_q;
  assign cls = ir_class(ir_q);
  // only under the run instruction in idle [RULE2]
  assign run_active = (cls == `BTP_CL_RUN) && (st_q == `BTP_ST_RTI);

  // 16-bit generators over cells 15..0 only [RULE3] [RULE23]
  btp_lfsr #(.W(16), .TAPS(`BTP_TAPS16)) u_prpg16 (
    .state(sh_q[`BTP_IN_HI:`BTP_OUT_LO]),
    .fold(16'h0000),
    .next(prpg16)
  );
  btp_lfsr #(.W(16), .TAPS(`BTP_TAPS16)) u_psa16 (
    .state(sh_q[`BTP_IN_HI:`BTP_OUT_LO]),
    .fold({d_s, 8'h00}),
    .next(psa16)
  );
  // 8-bit generators, inputs compress and outputs generate [RULE23]
  btp_lfsr #(.W(8), .TAPS(`BTP_TAPS8)) u_psa8 (
    .state(sh_q[`BTP_IN_HI:`BTP_IN_LO]),
    .fold(d_s),
    .next(psa8)
  );
  btp_lfsr #(.W(8), .TAPS(`BTP_TAPS8)) u_prpg8 (
    .state(sh_q[`BTP_OUT_HI:`BTP_OUT_LO]),
    .fold(8'h00),
    .next(prpg8)
  );

  // serial bit of the selected path
  always @* begin
    if ((st_q == `BTP_ST_SIR) || (st_q == `BTP_ST_E1I)) begin
      serial_bit = ir_sh_q[0];
    end else begin
      case (cls)
        `BTP_CL_BSCAN: serial_bit = sh_q[0];
        `BTP_CL_SAMPLE: serial_bit = sh_q[0];
        `BTP_CL_CTLSCAN: serial_bit = sel_sh_q[0];
        default: serial_bit = byp_q;
      endcase
    end
  end

  always @(posedge CLK) begin
    if (!RESETN) begin
      tck_p_q <= 1'b0;
      st_q <= `BTP_ST_TLR;
      ir_sh_q <= `BTP_IR_RESET;
      byp_q <= 1'b0;
      sh_q <= `BTP_BSR_RESET;
      upd_q <= `BTP_BSR_RESET;
      sel_sh_q <= `BTP_OPSEL_RESET;
      sel_q <= `BTP_OPSEL_RESET;
    end else begin
      tck_p_q <= tck_s;
      if (tck_rise) begin
        st_q <= tap_next(st_q, tms_s); // [RULE14]
        case (st_q)
          `BTP_ST_CIR: begin
            ir_sh_q <= `BTP_IR_CAPTURE; // [RULE18]
          end
          `BTP_ST_SIR: begin
            ir_sh_q <= {tdi_s, ir_sh_q[`BTP_IR_W-1:1]}; // [RULE17]
          end
          `BTP_ST_CDR: begin
            byp_q <= 1'b0;
            if ((cls == `BTP_CL_BSCAN) || (cls == `BTP_CL_SAMPLE)) begin
              sh_q <= {upd_q[`BTP_BIT_CLKCTL:`BTP_BIT_OE], d_s, CORE_Q};
            end
          end
          `BTP_ST_SDR: begin
            byp_q <= tdi_s; // [RULE17]
            if ((cls == `BTP_CL_BSCAN) || (cls == `BTP_CL_SAMPLE)) begin
              sh_q <= {tdi_s, sh_q[`BTP_BSR_W-1:1]};
            end
            if (cls == `BTP_CL_CTLSCAN) begin
              sel_sh_q <= {tdi_s, sel_sh_q[`BTP_OPSEL_W-1:1]};
            end
          end
          `BTP_ST_RTI: begin
            if (run_active) begin
              // two select bits, nothing else, pick the step [RULE1] [RULE24]
              case (sel_q)
                `BTP_OPSEL_TOGGLE: begin
                  sh_q[`BTP_IN_HI:`BTP_IN_LO] <= d_s; // [RULE5]
                  sh_q[`BTP_OUT_HI:`BTP_OUT_LO] <= ~sh_q[`BTP_OUT_HI:`BTP_OUT_LO]; // [RULE6]
                end
                `BTP_OPSEL_PATTERN: begin
                  // zero seed maps to zero [RULE7] [RULE8]
                  sh_q[`BTP_IN_HI:`BTP_OUT_LO] <= prpg16;
                end
                `BTP_OPSEL_SIGNATURE: begin
                  sh_q[`BTP_IN_HI:`BTP_OUT_LO] <= psa16; // [RULE10]
                end
                `BTP_OPSEL_COMBINED: begin
                  sh_q[`BTP_IN_HI:`BTP_IN_LO] <= psa8; // [RULE12]
                  sh_q[`BTP_OUT_HI:`BTP_OUT_LO] <= prpg8; // [RULE13] [RULE8]
                end
                default: begin
                  sh_q <= sh_q;
                end
              endcase
            end
          end
          default: begin
            byp_q <= byp_q;
          end
        endcase
      end
      if (tck_fall) begin
        if (st_q == `BTP_ST_UDR) begin
          if (cls == `BTP_CL_BSCAN) begin
            upd_q <= sh_q;
          end
          if (cls == `BTP_CL_CTLSCAN) begin
            sel_q <= sel_sh_q;
          end
        end
        if (run_active) begin
          upd_q[`BTP_IN_HI:`BTP_IN_LO] <= sh_q[`BTP_IN_HI:`BTP_IN_LO]; // [RULE5] [RULE10]
          if (sel_q != `BTP_OPSEL_SIGNATURE) begin
            upd_q[`BTP_OUT_HI:`BTP_OUT_LO] <= sh_q[`BTP_OUT_HI:`BTP_OUT_LO]; // [RULE6] [RULE7]
          end // output shadows held in signature mode [RULE11]
        end
      end
    end
  end

  // serial output only moves on the falling edge [RULE15] [RULE21]
  always @(posedge CLK) begin
    if (!RESETN) begin
      TDO_OUT <= 1'b0;
      TDO_OE <= 1'b0;
    end else if (tck_fall) begin
      TDO_OUT <= serial_bit;
      TDO_OE <= (st_q == `BTP_ST_SIR) || (st_q == `BTP_ST_SDR);
    end
  end

  // reset instruction also waits for a fall, so pins never switch on a rise [RULE15]
  always @(posedge CLK) begin
    if (!RESETN) begin
      ir_q <= `BTP_IR_RESET;
    end else if (tck_fall) begin
      if (st_q == `BTP_ST_TLR) begin
        ir_q <= `BTP_IR_RESET;
      end
      if (st_q == `BTP_ST_UIR) begin
        ir_q <= ir_sh_q; // [RULE22]
      end
    end
  end

  // pins and core follow the shadow latches in test mode
  always @(posedge CLK) begin
    if (!RESETN) begin
      Q_OUT <= 8'h00;
      Q_OE <= 1'b0;
      CORE_D <= 8'h00;
      TEST_MODE <= 1'b0;
    end else begin
      TEST_MODE <= is_test(ir_q);
      if (is_test(ir_q)) begin
        Q_OUT <= upd_q[`BTP_OUT_HI:`BTP_OUT_LO]; // [RULE15]
        Q_OE <= upd_q[`BTP_BIT_OE]; // [RULE4]
        CORE_D <= upd_q[`BTP_IN_HI:`BTP_IN_LO];
      end else begin
        Q_OUT <= CORE_Q;
        Q_OE <= 1'b1;
        CORE_D <= d_s;
      end
    end
  end
endmodule // btp_boundary_test
`default_nettype wire

// ### logic/btp_defines.vh
`ifndef BTP_DEFINES_VH
`define BTP_DEFINES_VH
// tap controller states
`define BTP_ST_W 4
`define BTP_ST_TLR 4'h0
`define BTP_ST_RTI 4'h1
`define BTP_ST_SDS 4'h2
`define BTP_ST_CDR 4'h3
`define BTP_ST_SDR 4'h4
`define BTP_ST_E1D 4'h5
`define BTP_ST_PDR 4'h6
`define BTP_ST_E2D 4'h7
`define BTP_ST_UDR 4'h8
`define BTP_ST_SIS 4'h9
`define BTP_ST_CIR 4'hA
`define BTP_ST_SIR 4'hB
`define BTP_ST_E1I 4'hC
`define BTP_ST_PIR 4'hD
`define BTP_ST_E2I 4'hE
`define BTP_ST_UIR 4'hF
// instruction register
`define BTP_IR_W 8
`define BTP_IR_CAPTURE 8'h81
`define BTP_IR_RESET 8'hFF
`define BTP_IR_CODE_MASK 8'h7F
`define BTP_OP_SAMPLE 8'h02
`define BTP_OP_EXTEST 8'h03
`define BTP_OP_RUN_OPERATION_INSTRUCTION 8'h09
`define BTP_OP_SCANCN 8'h0E
`define BTP_OP_SCANCT 8'h0F
// instruction classes
`define BTP_CL_W 3
`define BTP_CL_BYPASS 3'h0
`define BTP_CL_BSCAN 3'h1
`define BTP_CL_SAMPLE 3'h2
`define BTP_CL_RUN 3'h3
`define BTP_CL_CTLSCAN 3'h4
// boundary cell chain layout
`define BTP_BSR_W 18
`define BTP_BSR_RESET 18'h00000
`define BTP_BIT_CLKCTL 17
`define BTP_BIT_OE 16
`define BTP_IN_HI 15
`define BTP_IN_LO 8
`define BTP_OUT_HI 7
`define BTP_OUT_LO 0
`define BTP_DATA_W 8
// test operation select field
`define BTP_OPSEL_W 2
`define BTP_OPSEL_RESET 2'h0
`define BTP_OPSEL_TOGGLE 2'h0
`define BTP_OPSEL_PATTERN 2'h1
`define BTP_OPSEL_SIGNATURE 2'h2
`define BTP_OPSEL_COMBINED 2'h3
// feedback polynomials, x^16+x^14+x^13+x^11+1 and x^8+x^6+x^5+x^4+1
`define BTP_TAPS16 16'hB400
`define BTP_TAPS8 8'hB8
`define BTP_SYNC_W 11
`define BTP_SYNC_TCK 10
`define BTP_SYNC_TMS 9
`define BTP_SYNC_TDI 8
`endif

// ### logic/btp_sync.v
`default_nettype none
module btp_sync #(
  parameter W = 1
) (
  input wire clk,
  input wire resetn,
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta_q;
      reg sync_q;
      always @(posedge clk) begin
        if (!resetn) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else begin
          meta_q <= async_in[i];
          sync_q <= meta_q;
        end
      end
      assign sync_out[i] = sync_q;
    end
  endgenerate
endmodule // btp_sync
`default_nettype wire

// ### logic/btp_lfsr.v
`default_nettype none
// one step of a shift-left lfsr; fold is zero for pattern generation
module btp_lfsr #(
  parameter W = 16,
  parameter [W-1:0] TAPS = {W{1'b0}}
) (
  input wire [W-1:0] state,
  input wire [W-1:0] fold,
  output wire [W-1:0] next
);
  wire feedback;
  assign feedback = ^(state & TAPS);
  assign next = {state[W-2:0], feedback} ^ fold;
endmodule // btp_lfsr
`default_nettype wire

// ### verification/btp_boundary_test_assertions.sv
`default_nettype none
module btp_boundary_test_assertions (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic TCK,
  input wire logic [7:0] CORE_Q,
  input wire logic TDO_OUT,
  input wire logic TDO_OE,
  input wire logic [7:0] Q_OUT,
  input wire logic Q_OE,
  input wire logic [7:0] CORE_D,
  input wire logic TEST_MODE
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  // tck seen low on the last three samples
  sequence tck_low3;
    !$past(TCK) && !$past(TCK, 2) && !$past(TCK, 3);
  endsequence
  sequence oe_on8;
    TDO_OE [*8];
  endsequence
  wire logic in_test = TEST_MODE;
  chk_tdo_on_fall: assert property ($changed(TDO_OUT) |-> tck_low3)
    else $error("serial output moved off a falling edge");
  chk_oe_on_fall: assert property ($changed(TDO_OE) |-> tck_low3)
    else $error("serial enable moved off a falling edge");
  chk_oe_span: assert property ($rose(TDO_OE) |-> oe_on8)
    else $error("serial enable too short");
  chk_q_on_fall: assert property (in_test && $past(in_test) && $changed(Q_OUT) |-> tck_low3)
    else $error("data output moved off a falling edge");
  chk_cored_on_fall: assert property (in_test && $past(in_test) && $changed(CORE_D) |-> tck_low3)
    else $error("core input moved off a falling edge");
  chk_qoe_on_fall: assert property ($changed(Q_OE) && $past(RESETN, 2) |-> tck_low3)
    else $error("output enable moved off a falling edge");
  chk_ir_on_fall: assert property ($changed(TEST_MODE) |-> tck_low3)
    else $error("instruction changed off a falling edge");
  chk_normal_path: assert property (!in_test && !$past(in_test) && $past(RESETN, 2)
    |-> Q_OUT == $past(CORE_Q) && Q_OE)
    else $error("normal path disturbed outside run");
endmodule // btp_boundary_test_assertions
`default_nettype wire

// ### verification/btp_tap_ctl.sv
`default_nettype none
module btp_tap_ctl (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // one tck period; tms and tdi move only while tck is low
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #32;
    o = tdo;
    tck = 1'b1;
    #32;
    tck = 1'b0;
  endtask
  task automatic reset_tap();
    logic o;
    repeat (5) step(1'b1, ~tdi, o);
    step(1'b0, ~tdi, o);
  endtask
  // idle to idle, n bits lsb first, seed scanned before any run
  task automatic scan(input logic ir, input int n, input logic [17:0] din,
                      output logic [17:0] dout);
    logic o;
    int i;
    dout = 18'h00000;
    step(1'b1, ~tdi, o);
    if (ir) step(1'b1, ~tdi, o);
    step(1'b0, ~tdi, o);
    step(1'b0, ~tdi, o);
    for (i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, ~tdi, o);
    step(1'b0, ~tdi, o);
  endtask
endmodule // btp_tap_ctl
`default_nettype wire

// ### verification/tb.sv
`include "btp_defines.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic CLK, RESETN, TCK, TMS, TDI, TDO_OUT, TDO_OE, Q_OE, TEST_MODE;
  logic [7:0] D, CORE_Q, Q_OUT, CORE_D;
  wire logic tdo_pin = TDO_OE ? TDO_OUT : ~TDO_OUT;
  int bad_count = 0;
  int comparisons = 0;
  btp_boundary_test btp_boundary_test_inst (.CLK(CLK), .RESETN(RESETN), .TCK(TCK), .TMS(TMS),
    .TDI(TDI), .D(D), .CORE_Q(CORE_Q), .TDO_OUT(TDO_OUT), .TDO_OE(TDO_OE), .Q_OUT(Q_OUT),
    .Q_OE(Q_OE), .CORE_D(CORE_D), .TEST_MODE(TEST_MODE));
  btp_tap_ctl btp_tap_ctl_inst (.tck(TCK), .tms(TMS), .tdi(TDI), .tdo(tdo_pin));
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // cells 15..0 after one rise of the selected operation
  function automatic logic [15:0] next_cells(logic [1:0] sel, logic [15:0] s, logic [7:0] d);
    case (sel)
      2'h0: return {d, ~s[7:0]};
      2'h1: return {s[14:0], ^(s & `BTP_TAPS16)};
      2'h2: return {s[14:0], ^(s & `BTP_TAPS16)} ^ {d, 8'h00};
      default: return {{s[14:8], ^(s[15:8] & `BTP_TAPS8)} ^ d, s[6:0], ^(s[7:0] & `BTP_TAPS8)};
    endcase
  endfunction
  task automatic t_bypass();
    logic [17:0] o;
    D = 8'h5A;
    CORE_Q = 8'hC3;
    btp_tap_ctl_inst.reset_tap();
    btp_tap_ctl_inst.scan(1'b0, 3, 18'h00005, o);
    check(16'(o[2:0]), 16'h0002);
    check(16'(Q_OUT), 16'h00C3);
    check(16'(CORE_D), 16'h005A);
    check(16'(Q_OE), 16'h0001);
    btp_tap_ctl_inst.scan(1'b1, 8, 18'h00002, o);
    btp_tap_ctl_inst.scan(1'b0, 18, 18'h00000, o);
    check(o[15:0], 16'h5AC3);
    check(16'(TEST_MODE), 16'h0000);
  endtask
  task automatic run_mode(input logic [1:0] sel, input logic [15:0] seed, input logic oe,
                          input int n);
    logic [17:0] o;
    logic [15:0] s;
    int i;
    s = seed;
    btp_tap_ctl_inst.reset_tap();
    btp_tap_ctl_inst.scan(1'b1, 8, 18'h00003, o);
    check(16'(o[7:0]), 16'h0081);
    btp_tap_ctl_inst.scan(1'b0, 18, {1'b0, oe, seed}, o);
    btp_tap_ctl_inst.scan(1'b1, 8, 18'h0000E, o);
    btp_tap_ctl_inst.scan(1'b0, 2, {16'h0000, sel}, o);
    btp_tap_ctl_inst.scan(1'b1, 8, 18'h00009, o);
    check(16'(TEST_MODE), 16'h0001);
    for (i = 0; i < n; i++) begin
      btp_tap_ctl_inst.step(1'b0, ~TDI, o[0]);
      s = next_cells(sel, s, D);
    end
    #24;
    check(16'(Q_OUT), 16'((sel == 2'h2) ? seed[7:0] : s[7:0]));
    check(16'(CORE_D), 16'(s[15:8]));
    check(16'(Q_OE), 16'(oe));
  endtask
  initial begin
    RESETN = 1'b0;
    D = 8'hA5;
    CORE_Q = 8'h3C;
    repeat (3) @(posedge CLK);
    @(negedge CLK);
    RESETN = 1'b1;
    t_bypass();
    run_mode(2'h0, 16'h3C96, 1'b1, 3);
    run_mode(2'h1, 16'hACE1, 1'b1, 20);
    run_mode(2'h2, 16'h1234, 1'b1, 9);
    run_mode(2'h3, 16'h8001, 1'b1, 12);
    run_mode(2'h1, 16'h0000, 1'b0, 5);
    run_mode(2'h3, 16'h5500, 1'b1, 6);
    summarize();
  end
  initial begin
    #200000;
    bad_count++;
    summarize();
  end
endmodule // tb
bind btp_boundary_test btp_boundary_test_assertions btp_boundary_test_assertions_inst (
  .CLK(CLK), .RESETN(RESETN), .TCK(TCK), .CORE_Q(CORE_Q), .TDO_OUT(TDO_OUT), .TDO_OE(TDO_OE),
  .Q_OUT(Q_OUT), .Q_OE(Q_OE), .CORE_D(CORE_D), .TEST_MODE(TEST_MODE));
`default_nettype wire
